// ### design/lgc_regs.sv
// global control registers and the line-side controls they steer
//
// Operation
// - rate bit 0 gives E1, 1 gives T1/J1
// - mute enable zeroes data outputs on loss
// - long window needs 4096 zeros for loss
// - normal window: 250 T1, 32 E1
// - tristate bit floats every output pin
// - tristate bit or low test pin floats
// - in host mode, tx handover takes on/off from pins
// - in host mode, termination handover takes select from pin
// - slicer field trims threshold five percent
// - eq field cuts gain 1 or 3 dB
// - all bits read/write except the upper four of the first register (read as zero), reset to zero
`default_nettype none
module lgc_regs
   import lgc_pkg::*;
(
   input  wire logic                    ref_clk_in,
   input  wire logic                    sys_rst_in,
   input  wire logic [lgc_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [lgc_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                    wr_in,
   input  wire logic                    rd_in,
   output logic      [lgc_pkg::DATA_W-1:0] rdata_out,
   input  wire logic                    host_mode_in,
   input  wire logic                    test_pin_n_in,
   input  wire logic [lgc_pkg::NUM_CH-1:0] tx_enable_pin_n_in,
   input  wire logic                    rx_termination_pin_in,
   input  wire logic [lgc_pkg::NUM_CH-1:0] tx_on_reg_in,
   input  wire logic                    rx_termination_reg_in,
   input  wire logic [lgc_pkg::NUM_CH-1:0] rx_bit_valid_in,
   input  wire logic [lgc_pkg::NUM_CH-1:0] rx_bit_one_in,
   input  wire logic [lgc_pkg::NUM_CH-1:0] rx_pos_raw_in,
   input  wire logic [lgc_pkg::NUM_CH-1:0] rx_neg_raw_in,
   output logic                         synth_rate_select_out,
   output logic      [lgc_pkg::NUM_CH-1:0] rx_signal_loss_out,
   output logic      [lgc_pkg::NUM_CH-1:0] rx_pos_data_out,
   output logic      [lgc_pkg::NUM_CH-1:0] rx_neg_violation_out,
   output logic                         pins_tristate_n_out,
   output lgc_pkg::lgc_gauge_t          cable_gauge_out,
   output logic      [lgc_pkg::NUM_CH-1:0] tx_on_out,
   output logic                         rx_termination_select_out,
   output lgc_pkg::lgc_slice_t          slicer_level_out,
   output lgc_pkg::lgc_eq_t             eq_gain_trim_out
);
   import lgc_pkg::*;

   // ***********************************
   // pin synchronisers
   // ***********************************
   logic [NUM_CH-1:0] txen_meta_q;
   logic [NUM_CH-1:0] txen_sync_q;
   logic              test_meta_q;
   logic              test_sync_q;
   logic              term_meta_q;
   logic              term_sync_q;

   // test pin resets to the inactive level so reset never floats the pins
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         txen_meta_q <= 4'hF;
         txen_sync_q <= 4'hF;
         test_meta_q <= 1'b1;
         test_sync_q <= 1'b1;
         term_meta_q <= 1'b0;
         term_sync_q <= 1'b0;
      end
      else
      begin
         txen_meta_q <= tx_enable_pin_n_in;
         txen_sync_q <= txen_meta_q;
         test_meta_q <= test_pin_n_in;
         test_sync_q <= test_meta_q;
         term_meta_q <= rx_termination_pin_in;
         term_sync_q <= term_meta_q;
      end
   end

   // ***********************************
   // register file
   // ***********************************
   logic [DATA_W-1:0] rate_los_q;
   logic [DATA_W-1:0] rx_tune_q;
   logic [DATA_W-1:0] rdata_q;
   wire               sel_rate_los = (addr_in == RATE_LOS_ADDR);
   wire               sel_rx_tune  = (addr_in == RX_TUNE_ADDR);
   // upper bits of the first register (clock selects) live elsewhere, read as zero
   wire [DATA_W-1:0]  rd_mux = sel_rate_los ? (rate_los_q & RATE_LOS_MASK) :
                              sel_rx_tune  ? rx_tune_q : UNMAPPED_DATA;

   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         rate_los_q <= RATE_LOS_RESET;
         rx_tune_q  <= RX_TUNE_RESET;
         rdata_q    <= 8'h00;
      end
      else
      begin
         if (wr_in && sel_rate_los)
            rate_los_q <= wdata_in & RATE_LOS_MASK;
         if (wr_in && sel_rx_tune)
            rx_tune_q <= wdata_in;
         rdata_q <= rd_in ? rd_mux : 8'h00;
      end
   end
   assign rdata_out = rdata_q;

   // ***********************************
   // decoded controls
   // ***********************************
   wire              rate_t1     = rate_los_q[SYNTH_RATE_BIT];
   wire              mute_en     = rate_los_q[LOSS_MUTE_BIT];
   wire              long_win    = rate_los_q[LONG_LOSS_BIT];
   wire [1:0]        gauge_f     = {rx_tune_q[GAUGE_HI_BIT], rx_tune_q[GAUGE_LO_BIT]};
   wire [1:0]        slice_f     = {rx_tune_q[SLICER_HI_BIT], rx_tune_q[SLICER_LO_BIT]};
   wire [1:0]        eq_f        = {rx_tune_q[EQ_HI_BIT], rx_tune_q[EQ_LO_BIT]};
   wire              tx_hand     = host_mode_in && rx_tune_q[TX_HANDOVER_BIT];
   wire              term_hand   = host_mode_in && rx_tune_q[TERM_HANDOVER_BIT];
   wire              float_d     = rate_los_q[TRISTATE_BIT] || !test_sync_q;
   wire [NUM_CH-1:0] tx_on_d     = tx_hand ? ~txen_sync_q : tx_on_reg_in;
   wire              term_d      = term_hand ? term_sync_q : rx_termination_reg_in;
   // loss threshold: rate bit chooses T1 or E1 count
   wire [LOSS_CNT_W-1:0] loss_lim = long_win ? LOSS_LONG_BITS :
                                    (rate_t1 ? LOSS_T1_BITS : LOSS_E1_BITS);
   lgc_slice_t slice_d;
   lgc_eq_t    eq_d;
   // both 00 and 11 mean normal, so 11 folds onto normal
   assign slice_d = (slice_f == 2'h1) ? LGC_SLICE_LOW5 :
                    (slice_f == 2'h2) ? LGC_SLICE_HIGH5 : LGC_SLICE_NORMAL;
   assign eq_d    = (eq_f == 2'h1) ? LGC_EQ_CUT1DB :
                    (eq_f == 2'h2) ? LGC_EQ_CUT3DB : LGC_EQ_NORMAL;

   // outputs registered one edge after the register updates
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         synth_rate_select_out     <= 1'b0;
         pins_tristate_n_out       <= 1'b1;
         cable_gauge_out           <= LGC_GAUGE_22_24;
         tx_on_out                 <= 4'h0;
         rx_termination_select_out <= 1'b0;
         slicer_level_out          <= LGC_SLICE_NORMAL;
         eq_gain_trim_out          <= LGC_EQ_NORMAL;
      end
      else
      begin
         synth_rate_select_out     <= rate_t1;
         pins_tristate_n_out       <= !float_d;
         cable_gauge_out           <= lgc_gauge_t'(gauge_f);
         tx_on_out                 <= tx_on_d;
         rx_termination_select_out <= term_d;
         slicer_level_out          <= slice_d;
         eq_gain_trim_out          <= eq_d;
      end
   end

   // ***********************************
   // per-channel zero counting and mute
   // ***********************************
   logic [LOSS_CNT_W-1:0] zcnt_q [NUM_CH];
   logic [NUM_CH-1:0]     loss_q;
   logic [NUM_CH-1:0]     pos_q;
   logic [NUM_CH-1:0]     neg_q;

   // loss clears on any one bit; a lower limit applies at the next clock edge, without waiting for a bit
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++)
      begin : g_ch
         wire at_lim = (zcnt_q[ch] >= loss_lim);
         wire mute   = mute_en && loss_q[ch];
         always_ff @(posedge ref_clk_in)
         begin
            if (sys_rst_in)
            begin
               zcnt_q[ch] <= 13'h0000;
               loss_q[ch] <= 1'b0;
               pos_q[ch]  <= 1'b0;
               neg_q[ch]  <= 1'b0;
            end
            else
            begin
               if (rx_bit_valid_in[ch])
               begin
                  if (rx_bit_one_in[ch])
                     zcnt_q[ch] <= 13'h0000;
                  else if (!at_lim)
                     zcnt_q[ch] <= zcnt_q[ch] + 13'h0001;
               end
               loss_q[ch] <= at_lim && !(rx_bit_valid_in[ch] && rx_bit_one_in[ch]);
               pos_q[ch]  <= mute ? 1'b0 : rx_pos_raw_in[ch];
               neg_q[ch]  <= mute ? 1'b0 : rx_neg_raw_in[ch];
            end
         end
      end
   endgenerate
   assign rx_signal_loss_out   = loss_q;
   assign rx_pos_data_out      = pos_q;
   assign rx_neg_violation_out = neg_q;

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   chk_rate_follow: assert property (wr_in && sel_rate_los ##1 1'b1 |=>
      synth_rate_select_out == $past(wdata_in[SYNTH_RATE_BIT], 2))
      else $error("rate output does not follow write");
   chk_mute_data: assert property (mute_en && loss_q[0] |=> !rx_pos_data_out[0]
      && !rx_neg_violation_out[0])
      else $error("data not muted on loss");
   chk_long_window: assert property (rx_signal_loss_out[0] && long_win && $stable(long_win)
      |-> $past(zcnt_q[0]) >= LOSS_LONG_BITS)
      else $error("loss before 4096 zeros");
   chk_e1_window: assert property (!long_win && !rate_t1 && rx_signal_loss_out[0]
      && $stable(rate_los_q) |-> $past(zcnt_q[0]) >= LOSS_E1_BITS)
      else $error("loss before 32 zeros");
   chk_tristate_bit: assert property (rate_los_q[TRISTATE_BIT] |=> !pins_tristate_n_out)
      else $error("pins not floated");
   chk_test_pin: assert property (!test_sync_q |=> !pins_tristate_n_out)
      else $error("test pin not honoured");
   chk_tx_handover: assert property (tx_hand |=> tx_on_out == ~$past(txen_sync_q))
      else $error("tx on not from pins");
   chk_term_handover: assert property (term_hand |=> rx_termination_select_out
      == $past(term_sync_q))
      else $error("termination not from pin");
   chk_slicer_map: assert property (slice_f == 2'h3 |=> slicer_level_out == LGC_SLICE_NORMAL)
      else $error("slicer 11 not normal");
   chk_eq_map: assert property (eq_f == 2'h2 |=> eq_gain_trim_out == LGC_EQ_CUT3DB)
      else $error("eq 10 not 3 dB cut");
   chk_reg_readback: assert property (wr_in && sel_rx_tune ##1 rd_in && sel_rx_tune
      && !wr_in |=> rdata_out == $past(wdata_in, 2))
      else $error("readback mismatch");

   // ***********************************
   // bus, decode, loss and mute checks
   // ***********************************
   // multi-step behaviours are built from these
   sequence s_tune_write;
      wr_in && sel_rx_tune;
   endsequence
   sequence s_rate_read;
      rd_in && sel_rate_los;
   endsequence
   sequence s_ch0_one;
      rx_bit_valid_in[0] && rx_bit_one_in[0];
   endsequence

   chk_gauge_follow: assert property (s_tune_write ##1 1'b1 |=>
      cable_gauge_out == lgc_gauge_t'($past(wdata_in[GAUGE_HI_BIT -: 2], 2)))
      else $error("gauge output does not follow write");
   chk_upper_bits: assert property (s_rate_read |=> rdata_out[7:4] == 4'h0)
      else $error("clock select bits not read as zero");
   chk_unmapped_read: assert property (rd_in && !sel_rate_los && !sel_rx_tune
      |=> rdata_out == UNMAPPED_DATA)
      else $error("unmapped read not zero");
   chk_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data outside read cycle");
   chk_slicer_low: assert property (slice_f == 2'h1 |=> slicer_level_out == LGC_SLICE_LOW5)
      else $error("slicer 01 not low");
   chk_eq_cut1: assert property (eq_f == 2'h1 |=> eq_gain_trim_out == LGC_EQ_CUT1DB)
      else $error("eq 01 not 1 dB cut");
   // without hand-over the register path must win
   chk_tx_regs: assert property (!tx_hand |=> tx_on_out == $past(tx_on_reg_in))
      else $error("tx on not from registers");
   chk_term_regs: assert property (!term_hand |=> rx_termination_select_out
      == $past(rx_termination_reg_in))
      else $error("termination not from registers");
   chk_float_release: assert property (!rate_los_q[TRISTATE_BIT] && test_sync_q
      |=> pins_tristate_n_out)
      else $error("pins floated with no request");
   chk_loss_clear: assert property (s_ch0_one |=> !rx_signal_loss_out[0])
      else $error("loss held after a one");
   chk_mute_pass: assert property (!(mute_en && loss_q[0])
      |=> rx_pos_data_out[0] == $past(rx_pos_raw_in[0]))
      else $error("data muted without loss");
   chk_t1_window: assert property (!long_win && rate_t1 && rx_signal_loss_out[0]
      && $stable(rate_los_q) |-> $past(zcnt_q[0]) >= LOSS_T1_BITS)
      else $error("loss before 250 zeros");
endmodule : lgc_regs
`default_nettype wire

// ### design/lgc_pkg.sv
// package for the line interface global control register bank
`default_nettype none
package lgc_pkg;
   // register bus
   localparam int               ADDR_W          = 7;
   localparam int               DATA_W          = 8;
   localparam logic [6:0]       RATE_LOS_ADDR   = 7'h41;
   localparam logic [6:0]       RX_TUNE_ADDR    = 7'h42;
   localparam logic [7:0]       RATE_LOS_RESET  = 8'h00;
   localparam logic [7:0]       RX_TUNE_RESET   = 8'h00;
   localparam logic [7:0]       RATE_LOS_MASK   = 8'h0F;
   localparam logic [7:0]       UNMAPPED_DATA   = 8'h00;
   // clock_rate_and_los_control field positions
   localparam int               SYNTH_RATE_BIT  = 3;
   localparam int               LOSS_MUTE_BIT   = 2;
   localparam int               LONG_LOSS_BIT   = 1;
   localparam int               TRISTATE_BIT    = 0;
   // line_receiver_tuning field positions
   localparam int               GAUGE_HI_BIT    = 7;
   localparam int               GAUGE_LO_BIT    = 6;
   localparam int               TX_HANDOVER_BIT = 5;
   localparam int               TERM_HANDOVER_BIT = 4;
   localparam int               SLICER_HI_BIT   = 3;
   localparam int               SLICER_LO_BIT   = 2;
   localparam int               EQ_HI_BIT       = 1;
   localparam int               EQ_LO_BIT       = 0;
   // channels and loss counts in line bits
   localparam int               NUM_CH          = 4;
   localparam int               LOSS_CNT_W      = 13;
   localparam logic [12:0]      LOSS_LONG_BITS  = 13'h1000;
   localparam logic [12:0]      LOSS_T1_BITS    = 13'h00FA;
   localparam logic [12:0]      LOSS_E1_BITS    = 13'h0020;
   // decoded cable, slicer and equalizer settings
   typedef enum logic [1:0] {LGC_GAUGE_22_24, LGC_GAUGE_22, LGC_GAUGE_24, LGC_GAUGE_26}
      lgc_gauge_t;
   typedef enum logic [1:0] {LGC_SLICE_NORMAL, LGC_SLICE_LOW5, LGC_SLICE_HIGH5} lgc_slice_t;
   typedef enum logic [1:0] {LGC_EQ_NORMAL, LGC_EQ_CUT1DB, LGC_EQ_CUT3DB} lgc_eq_t;
endpackage : lgc_pkg
`default_nettype wire

// ### tb/lgc_host_model.sv
// host processor model driving the register port
`default_nettype none
module lgc_host_model
   import lgc_pkg::*;
(
   input  wire logic                        clk_in,
   input  wire logic [lgc_pkg::DATA_W-1:0]  rdata_in,
   output logic      [lgc_pkg::ADDR_W-1:0]  addr_out,
   output logic      [lgc_pkg::DATA_W-1:0]  wdata_out,
   output logic                             wr_out,
   output logic                             rd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      addr_out = 7'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // data inverted after the strobe, so a stale bus is never trusted
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
   endtask
   task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
      // read data stand in the cycle after the strobe; take them at its closing edge
      @(posedge clk_in);
      d = rdata_in;
   endtask
   // write followed at once by a read of the same address, no gap between strobes
   task automatic wr_rd(input logic [6:0] a, input logic [7:0] wd, output logic [7:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= wd;
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      rd_out    <= 1'b1;
      wdata_out <= ~wd;
      @(posedge clk_in);
      rd_out    <= 1'b0;
      @(posedge clk_in);
      d = rdata_in;
   endtask
endmodule // lgc_host_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the global control register bank
`default_nettype none
module tb_top;
   import lgc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, hmode, tpin_n, term_pin, term_reg;
   logic [3:0] txpin_n, txreg, bv, b1, rp, rn;
   logic [6:0] addr;
   logic [7:0] wdata, rdata, d;
   logic       wr, rd, rate, tri_n, term;
   logic [3:0] loss, pos, neg, txon;
   lgc_gauge_t gauge;
   lgc_slice_t slice;
   lgc_eq_t    eq;
   int         fail_count = 0;
   int         n_compared = 0;
   lgc_host_model h (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   lgc_regs dut (.ref_clk_in(clk), .sys_rst_in(rst), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .host_mode_in(hmode),
      .test_pin_n_in(tpin_n), .tx_enable_pin_n_in(txpin_n), .rx_termination_pin_in(term_pin),
      .tx_on_reg_in(txreg), .rx_termination_reg_in(term_reg), .rx_bit_valid_in(bv),
      .rx_bit_one_in(b1), .rx_pos_raw_in(rp), .rx_neg_raw_in(rn),
      .synth_rate_select_out(rate), .rx_signal_loss_out(loss), .rx_pos_data_out(pos),
      .rx_neg_violation_out(neg), .pins_tristate_n_out(tri_n), .cable_gauge_out(gauge),
      .tx_on_out(txon), .rx_termination_select_out(term), .slicer_level_out(slice),
      .eq_gain_trim_out(eq));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic v);
      @(posedge clk);
      bv <= 4'hF;
      b1 <= {4{v}};
      @(posedge clk);
      bv <= 4'h0;
   endtask
   task automatic t_regs;
      h.rd_reg(RATE_LOS_ADDR, d);
      chk(d, 8'h00, "reset 41");
      h.rd_reg(RX_TUNE_ADDR, d);
      chk(d, 8'h00, "reset 42");
      chk({rate, tri_n, loss}, 8'h10, "reset outs");
      h.wr_rd(RX_TUNE_ADDR, 8'hA5, d);
      chk(d, 8'hA5, "back to back");
      h.wr_reg(RATE_LOS_ADDR, 8'hF9);
      cyc(1);
      chk({rate, tri_n}, 8'h02, "rate tristate");
      h.wr_reg(7'h40, 8'hFF);
      h.rd_reg(RATE_LOS_ADDR, d);
      chk(d, 8'h09, "rw 41");
      h.rd_reg(7'h7F, d);
      chk(d, UNMAPPED_DATA, "unmapped");
      h.wr_reg(RATE_LOS_ADDR, 8'h00);
      cyc(1);
      chk({rate, tri_n}, 8'h01, "rate e1");
      $display("test regs done");
   endtask
   task automatic t_tune;
      for (int i = 0; i < 4; i++)
      begin
         h.wr_reg(RX_TUNE_ADDR, {i[1:0], 2'b00, i[1:0], i[1:0]});
         cyc(1);
         chk(gauge, i, "gauge");
         chk(slice, (i == 3) ? 0 : i, "slicer");
         chk(eq, (i == 3) ? 0 : i, "eq");
         h.rd_reg(RX_TUNE_ADDR, d);
         chk(d, {i[1:0], 2'b00, i[1:0], i[1:0]}, "rw 42");
      end
      $display("test tuning done");
   endtask
   task automatic t_pins;
      hmode <= 1'b1;
      txpin_n <= 4'h5;
      txreg <= 4'h3;
      term_pin <= 1'b1;
      h.wr_reg(RX_TUNE_ADDR, 8'h30);
      cyc(5);
      chk(txon, 4'hA, "tx pins");
      chk(term, 1'b1, "term pin");
      h.wr_reg(RX_TUNE_ADDR, 8'h00);
      cyc(5);
      chk({txon, term}, 8'h06, "reg control");
      tpin_n <= 1'b0;
      cyc(5);
      chk(tri_n, 1'b0, "test pin");
      tpin_n <= 1'b1;
      cyc(5);
      chk(tri_n, 1'b1, "test pin off");
      $display("test pins done");
   endtask
   // one bit every other cycle keeps the count in line bits, not clocks
   task automatic t_loss(input logic [7:0] cfg, input int n);
      h.wr_reg(RATE_LOS_ADDR, cfg);
      send(1'b1);
      repeat (n - 1) send(1'b0);
      cyc(2);
      chk(loss, 4'h0, "early loss");
      send(1'b0);
      cyc(2);
      chk(loss, 4'hF, "loss");
      chk({pos, neg}, cfg[2] ? 8'h00 : 8'hFF, "mute");
      send(1'b1);
      cyc(2);
      chk({loss, pos}, 8'h0F, "loss clear");
      $display("test loss %0d done", n);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      {hmode, term_pin, term_reg, txpin_n, txreg, bv, b1} = '0;
      tpin_n = 1'b1;
      rp = 4'hF;
      rn = 4'hF;
      cyc(4);
      rst <= 1'b0;
      t_regs();
      t_tune();
      t_pins();
      t_loss(8'h04, 32);
      t_loss(8'h08, 250);
      t_loss(8'h06, 4096);
      report_and_stop();
   end
   initial
   begin
      #100000;
      fail_count++;
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
